/* src/flash_hv_pkg.sv */
// constants for the flash high-voltage program/erase control block
// assumes a 32-bit classic wishbone slave port and a 250 MHz system clock
package flash_hv_pkg;

  // register byte offsets
  localparam logic [3:0] HV_CONTROL_OFS = 4'h0;
  localparam logic [3:0] PULSE_CONTROL_OFS = 4'h4;

  // control word fields, little-endian index; msb-first bit n sits at 31-n
  localparam int HV_ACTIVE_BIT = 31;
  localparam int SCLK_RANGE_LSB = 27;
  localparam int SCLK_RANGE_W = 3;
  localparam int PERIOD_EXP_LSB = 24;
  localparam int PERIOD_EXP_W = 2;
  localparam int PERIOD_MUL_LSB = 16;
  localparam int PERIOD_MUL_W = 7;
  localparam int BLOCK_SEL_LSB = 8;
  localparam int BLOCK_CNT = 8;
  localparam int PROTECT_SEL_BIT = 6;
  localparam int ERASE_SEL_BIT = 2;
  localparam int ARMED_BIT = 1;

  // pulse control word fields
  localparam int PULSE_START_BIT = 0;
  localparam int PULSE_PHASE_BIT = 1;
  localparam int RECOVER_PHASE_BIT = 2;

  // reset values
  localparam logic [2:0] SCLK_RANGE_RST = 3'h0;
  localparam logic [1:0] PERIOD_EXP_RST = 2'h0;
  localparam logic [6:0] PERIOD_MUL_RST = 7'h00;
  localparam logic [7:0] BLOCK_SEL_RST = 8'h00;

  // clock range codes and scaling in half units
  localparam logic [2:0] SCLK_CODE_1A = 3'h0;
  localparam logic [2:0] SCLK_CODE_1 = 3'h1;
  localparam logic [2:0] SCLK_CODE_3H = 3'h2;
  localparam logic [2:0] SCLK_CODE_2 = 3'h3;
  localparam logic [2:0] SCLK_CODE_3 = 3'h4;
  localparam logic [2:0] SCLK_CODE_4 = 3'h5;
  localparam logic [3:0] HALF_SCALE_1 = 4'h2;
  localparam logic [3:0] HALF_SCALE_3H = 4'h3;
  localparam logic [3:0] HALF_SCALE_2 = 4'h4;
  localparam logic [3:0] HALF_SCALE_3 = 4'h6;
  localparam logic [3:0] HALF_SCALE_4 = 4'h8;

  // exponent offsets added for erase and protection operations
  localparam logic [3:0] EXP_ERASE_ADD = 4'h4;
  localparam logic [3:0] EXP_PROTECT_ADD = 4'h2;

  // recovery time after a pulse
  localparam int CLK_MHZ = 250;
  localparam int RECOVERY_NS = 1000;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS * CLK_MHZ + 999) / 1000;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PULSE = 3'b010,
    ST_RECOVER = 3'b100
  } hv_state_t;

endpackage : flash_hv_pkg

/* src/flash_program_erase_control.sv */
// high-voltage program/erase control register and pulse sequencer
// assumes a classic wishbone master on clk_i and a single array read port
// assumes array_req_i is made on clk_i, so it has no synchroniser
// assumes pump ramps and margin reads are handled outside this block
// How it works
// - status bit high during pulse and recovery
// - array accesses unacknowledged while high voltage active
// - armed bit frozen while high voltage active
// - high voltage status bit is read only
// - clock range field frozen while armed
// - clock range codes decode to scaling factors
// - exponent field with protect, erase sets N
// - exponent field frozen while armed
// - multiple field frozen while armed
// - eight block selects, bit 16 block 0
// - block selects frozen while armed, reset none
// - protect select chooses set or clear by erase
// - protect select frozen while armed
// - armed bit enables program or erase configuration
// - erase select chooses program or erase
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module flash_program_erase_control
  import flash_hv_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // flash array access port
  input wire logic array_req_i,
  output logic array_ack_o,
  // high voltage controls toward the array
  output logic high_voltage_active_o,
  output logic hv_pulse_o,
  output logic [7:0] block_select_o,
  output logic sequence_armed_o,
  output logic erase_select_o,
  output logic protect_set_o,
  output logic protect_clear_o,
  output logic [3:0] exp_multiplier_o,
  output logic [7:0] lin_multiplier_o
);

  // scaling code to half-cycle units; reserved codes fall back to 1
  // half units keep the 3/2 setting exact without a fraction counter
  function automatic logic [3:0] half_scale(input logic [2:0] code);
    case (code)
      SCLK_CODE_1A: half_scale = HALF_SCALE_1;
      SCLK_CODE_1: half_scale = HALF_SCALE_1;
      SCLK_CODE_3H: half_scale = HALF_SCALE_3H;
      SCLK_CODE_2: half_scale = HALF_SCALE_2;
      SCLK_CODE_3: half_scale = HALF_SCALE_3;
      SCLK_CODE_4: half_scale = HALF_SCALE_4;
      default: half_scale = HALF_SCALE_1;
    endcase
  endfunction : half_scale

  // byte-lane merge of a write into an old word
  // lanes not selected keep their stored value, so byte writes are safe
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] lanes);
    lane_merge = old_w;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        lane_merge[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
  endfunction : lane_merge

  // control fields
  // all cleared by rst_i only; there is no soft reset path
  logic [2:0] sclk_range_code_q;
  logic [1:0] period_exponent_q;
  logic [6:0] period_multiple_q;
  logic [7:0] block_sel_q;
  logic protect_set_clear_select_q;
  logic erase_select_q;
  logic sequence_armed_q;

  // sequencer
  // unit counter sized for 128 units shifted by the largest N of 9
  // recovery counter holds the package recovery cycle count
  hv_state_t state_q;
  hv_state_t state_d;
  logic hv_q;
  logic [3:0] tick_cnt_q;
  logic tick_q;
  logic [19:0] unit_cnt_q;
  logic [9:0] rec_cnt_q;

  // bus
  // ctrl_merged is the word as it would be after the write lands
  logic ack_q;
  logic [31:0] rdata_q;
  logic array_ack_q;
  logic [31:0] ctrl_word;
  logic [31:0] pulse_word;
  logic [31:0] ctrl_merged;
  logic bus_req;
  logic wr_ctrl;
  logic wr_pulse;
  logic start_req;
  logic [7:0] block_wr;
  logic [3:0] n_exp;
  logic [7:0] m_lin;
  logic [19:0] pulse_units;

  // block 0 sits at the highest index of the byte
  // a loop keeps the bit reversal in one place for read and write
  genvar gi;
  generate
    for (gi = 0; gi < BLOCK_CNT; gi++) begin : g_blk
      assign ctrl_word[BLOCK_SEL_LSB + BLOCK_CNT - 1 - gi] = block_sel_q[gi];
      assign block_wr[gi] = ctrl_merged[BLOCK_SEL_LSB + BLOCK_CNT - 1 - gi];
    end
  endgenerate

  // readback view; unnamed positions are reserved and read zero
  // the status bit is wired from the flop, so no write path reaches it
  assign ctrl_word[HV_ACTIVE_BIT] = hv_q;
  assign ctrl_word[HV_ACTIVE_BIT-1] = 1'b0;
  assign ctrl_word[SCLK_RANGE_LSB +: SCLK_RANGE_W] = sclk_range_code_q;
  assign ctrl_word[SCLK_RANGE_LSB-1] = 1'b0;
  assign ctrl_word[PERIOD_EXP_LSB +: PERIOD_EXP_W] = period_exponent_q;
  assign ctrl_word[PERIOD_EXP_LSB-1] = 1'b0;
  assign ctrl_word[PERIOD_MUL_LSB +: PERIOD_MUL_W] = period_multiple_q;
  assign ctrl_word[BLOCK_SEL_LSB-1] = 1'b0;
  assign ctrl_word[PROTECT_SEL_BIT] = protect_set_clear_select_q;
  assign ctrl_word[PROTECT_SEL_BIT-1:ERASE_SEL_BIT+1] = 3'h0;
  assign ctrl_word[ERASE_SEL_BIT] = erase_select_q;
  assign ctrl_word[ARMED_BIT] = sequence_armed_q;
  assign ctrl_word[0] = 1'b0;

  // pulse control view: start reads zero, phases show sequencer state
  // software can poll the phases without touching the control word
  always_comb begin
    pulse_word = 32'h0000_0000;
    pulse_word[PULSE_PHASE_BIT] = (state_q == ST_PULSE);
    pulse_word[RECOVER_PHASE_BIT] = (state_q == ST_RECOVER);
  end

  // request decode; writes land on the edge the master sees ack
  // a write that the master abandons before ack changes nothing
  // start needs lane 0, so an upper-lane write cannot fire a pulse
  assign bus_req = cyc_i & stb_i;
  assign ctrl_merged = lane_merge(ctrl_word, dat_i, sel_i);
  assign wr_ctrl = bus_req & ack_q & we_i & (adr_i == HV_CONTROL_OFS);
  assign wr_pulse = bus_req & ack_q & we_i & (adr_i == PULSE_CONTROL_OFS) & sel_i[0];
  assign start_req = wr_pulse & dat_i[PULSE_START_BIT];

  // one-cycle ack, dropped the cycle after; unmapped reads give zero
  // read data is captured on the request edge and held until the next access, read or write
  // unmapped writes are acked and dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q) begin
        case (adr_i)
          HV_CONTROL_OFS: rdata_q <= ctrl_word;
          PULSE_CONTROL_OFS: rdata_q <= pulse_word;
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // timing fields only move while no sequence is armed
  // freezing them keeps an armed pulse from changing width mid-sequence
  // a write while armed but not under high voltage still reaches the armed bit itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_range_code_q <= SCLK_RANGE_RST;
      period_exponent_q <= PERIOD_EXP_RST;
      period_multiple_q <= PERIOD_MUL_RST;
    end else if (wr_ctrl && !sequence_armed_q) begin
      sclk_range_code_q <= ctrl_merged[SCLK_RANGE_LSB +: SCLK_RANGE_W];
      period_exponent_q <= ctrl_merged[PERIOD_EXP_LSB +: PERIOD_EXP_W];
      period_multiple_q <= ctrl_merged[PERIOD_MUL_LSB +: PERIOD_MUL_W];
    end
  end

  // operation selects, likewise frozen while armed
  // erase select freezes too, so N cannot jump while armed
  // protect select picks set or clear through erase select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_sel_q <= BLOCK_SEL_RST;
      protect_set_clear_select_q <= 1'b0;
      erase_select_q <= 1'b0;
    end else if (wr_ctrl && !sequence_armed_q) begin
      block_sel_q <= block_wr;
      protect_set_clear_select_q <= ctrl_merged[PROTECT_SEL_BIT];
      erase_select_q <= ctrl_merged[ERASE_SEL_BIT];
    end
  end

  // armed bit cannot be changed under high voltage; status bit never written
  // a disarm attempt during a pulse is dropped, not queued for later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequence_armed_q <= 1'b0;
    end else if (wr_ctrl && !hv_q) begin
      sequence_armed_q <= ctrl_merged[ARMED_BIT];
    end
  end

  // multipliers: N from exponent, erase and protect; M is one plus field
  // N tops out at 9 and M at 128, so the unit count fits 20 bits
  // exponent adds for erase and protect come from the package
  always_comb begin
    n_exp = {2'b00, period_exponent_q};
    if (erase_select_q) begin
      n_exp = n_exp + EXP_ERASE_ADD;
    end
    if (protect_set_clear_select_q) begin
      n_exp = n_exp + EXP_PROTECT_ADD;
    end
    m_lin = {1'b0, period_multiple_q} + 8'h01;
    pulse_units = 20'({12'h000, m_lin} << n_exp);
  end

  // time base: one tick per scaled half-period; keeps pulse width
  // independent of bus clock choice across the legal range codes
  // counter idles at zero outside the pulse phase
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_PULSE) begin
      tick_cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == half_scale(sclk_range_code_q) - 4'h1) begin
      tick_cnt_q <= 4'h0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
      tick_q <= 1'b0;
    end
  end

  // sequencer next state; a pulse only starts on an armed sequence
  // a start written while busy is ignored rather than queued
  // recovery always follows a pulse; there is no abort path
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req && sequence_armed_q) begin
          state_d = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tick_q && unit_cnt_q == 20'h0_0001) begin
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (rec_cnt_q == 10'h001) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // state, status and counters
  // status follows the next state, so it rises on the start write edge
  // the unit count is reloaded while idle, ready for the next start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      hv_q <= 1'b0;
      unit_cnt_q <= 20'h0_0000;
      rec_cnt_q <= 10'h000;
    end else begin
      state_q <= state_d;
      hv_q <= (state_d != ST_IDLE);
      if (state_q == ST_IDLE) begin
        unit_cnt_q <= pulse_units;
      end else if (tick_q) begin
        unit_cnt_q <= unit_cnt_q - 20'h0_0001;
      end
      if (state_q != ST_RECOVER) begin
        rec_cnt_q <= 10'(RECOVERY_CYCLES);
      end else begin
        rec_cnt_q <= rec_cnt_q - 10'h001;
      end
    end
  end

  // array port: no ack while high voltage is up
  // the next-state term also blocks an ack in the start cycle itself
  // a held request gets a fresh ack every second cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      array_ack_q <= 1'b0;
    end else begin
      array_ack_q <= array_req_i & ~array_ack_q & ~hv_q & (state_d == ST_IDLE);
    end
  end

  // registered outputs toward the array, one cycle behind the fields
  // the lag is harmless: the array acts only once a pulse is running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_pulse_o <= 1'b0;
      block_select_o <= BLOCK_SEL_RST;
      erase_select_o <= 1'b0;
      protect_set_o <= 1'b0;
      protect_clear_o <= 1'b0;
      exp_multiplier_o <= 4'h0;
      lin_multiplier_o <= 8'h01;
    end else begin
      hv_pulse_o <= (state_d == ST_PULSE);
      block_select_o <= block_sel_q;
      erase_select_o <= erase_select_q;
      protect_set_o <= protect_set_clear_select_q & ~erase_select_q;
      protect_clear_o <= protect_set_clear_select_q & erase_select_q;
      exp_multiplier_o <= n_exp;
      lin_multiplier_o <= m_lin;
    end
  end

  // outputs that are already flops inside the block
  assign dat_o = rdata_q;
  assign ack_o = ack_q;
  assign array_ack_o = array_ack_q;
  assign high_voltage_active_o = hv_q;
  assign sequence_armed_o = sequence_armed_q;

endmodule : flash_program_erase_control

/* verif/flash_hv_sva.sv */
// assertions for the flash high-voltage control block
// assumes it is bound to the block's own ports
`timescale 1ns/1ps
module flash_hv_sva (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // array side and controls
  input wire logic array_ack_o,
  input wire logic high_voltage_active_o,
  input wire logic hv_pulse_o,
  input wire logic [7:0] block_select_o,
  input wire logic sequence_armed_o,
  input wire logic erase_select_o,
  input wire logic protect_set_o,
  input wire logic protect_clear_o,
  input wire logic [3:0] exp_multiplier_o,
  input wire logic [7:0] lin_multiplier_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // completions seen at the edge where ack is sampled
  sequence s_wr(a); ack_o && cyc_i && stb_i && we_i && adr_i == a; endsequence
  sequence s_rd; ack_o && cyc_i && stb_i && !we_i && adr_i == 4'h0; endsequence
  property p_start; s_wr(4'h4) ##0 dat_i[0] && sequence_armed_o && !high_voltage_active_o
    |=> high_voltage_active_o; endproperty
  a_start: assert property (p_start) else $error("pulse did not raise status");
  property p_hold; $rose(high_voltage_active_o) |-> high_voltage_active_o[*8]; endproperty
  a_hold: assert property (p_hold) else $error("status dropped too early");
  property p_arr; high_voltage_active_o |-> !array_ack_o; endproperty
  a_arr: assert property (p_arr) else $error("array ack during high voltage");
  property p_pls; hv_pulse_o |-> high_voltage_active_o; endproperty
  a_pls: assert property (p_pls) else $error("pulse phase without status");
  property p_arm; s_wr(4'h0) ##0 high_voltage_active_o |=> $stable(sequence_armed_o)[*2];
  endproperty
  a_arm: assert property (p_arm) else $error("armed bit changed during high voltage");
  property p_ro; s_wr(4'h0) ##0 !high_voltage_active_o |=> !high_voltage_active_o; endproperty
  a_ro: assert property (p_ro) else $error("status bit took a write");
  property p_blk; s_wr(4'h0) ##0 sequence_armed_o |=> $stable(block_select_o)[*2]; endproperty
  a_blk: assert property (p_blk) else $error("block selects changed while armed");
  property p_mul; s_wr(4'h0) ##0 sequence_armed_o
    |=> ($stable(exp_multiplier_o) && $stable(lin_multiplier_o))[*2]; endproperty
  a_mul: assert property (p_mul) else $error("multipliers changed while armed");
  property p_prot; s_wr(4'h0) ##0 sequence_armed_o
    |=> ($stable(protect_set_o) && $stable(protect_clear_o))[*2]; endproperty
  a_prot: assert property (p_prot) else $error("protect select changed while armed");
  property p_rdm; s_rd |-> lin_multiplier_o == {1'b0, dat_o[22:16]} + 8'h01 && exp_multiplier_o
    == dat_o[25:24] + (dat_o[2] ? 4'h4 : 4'h0) + (dat_o[6] ? 4'h2 : 4'h0); endproperty
  a_rdm: assert property (p_rdm) else $error("multiplier outputs disagree");
  property p_rds; s_rd |-> erase_select_o == dat_o[2] && protect_set_o == (dat_o[6] & ~dat_o[2])
    && protect_clear_o == (dat_o[6] & dat_o[2]) && block_select_o == {dat_o[8], dat_o[9],
    dat_o[10], dat_o[11], dat_o[12], dat_o[13], dat_o[14], dat_o[15]}; endproperty
  a_rds: assert property (p_rds) else $error("select outputs disagree");
  property p_rsv; s_rd |-> !dat_o[30] && !dat_o[26] && !dat_o[23] && !dat_o[7]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read as one");
endmodule : flash_hv_sva
bind flash_program_erase_control flash_hv_sva i_flash_hv_sva (.*);

/* verif/tb_top.sv */
// self-checking bench for the flash high-voltage control block
// assumes one clock, wishbone slave port and array request port
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, array_req_i, ack_o, array_ack_o;
  logic high_voltage_active_o, hv_pulse_o, sequence_armed_o, erase_select_o;
  logic protect_set_o, protect_clear_o;
  logic [3:0] adr_i, sel_i, exp_multiplier_o;
  logic [31:0] dat_i, dat_o, q, v;
  logic [7:0] block_select_o, lin_multiplier_o;
  int fails, checked, n;
  // last pulse phase width; range scalings 1, 1, 3/2, 2, 3, 4 doubled
  int pulse_len, pulse_run;
  int twice_scale[6] = '{32'h2, 32'h2, 32'h3, 32'h4, 32'h6, 32'h8};
  flash_program_erase_control i_flash_program_erase_control (.*);
  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // counts clocks of each pulse phase, kept once it ends
  always @(posedge clk_i) begin
    if (hv_pulse_o === 1'b1) begin
      pulse_run <= pulse_run + 1;
    end else if (pulse_run != 0) begin
      pulse_len <= pulse_run;
      pulse_run <= 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // one classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #40000;
    fails++;
    close_out();
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, array_req_i} = 5'h10;
    {adr_i, sel_i, dat_i} = {8'h0F, 32'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    chk(32'(lin_multiplier_o), 32'h1);
    // every field plus reserved and status bits while disarmed
    wb(1'b1, 4'h0, 32'hEFFF_FFFD);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h2B7F_FF44);
    chk({16'h0, block_select_o, lin_multiplier_o}, 32'h0000_FF80);
    chk(32'(exp_multiplier_o), 32'h9);
    // valid range codes with exponent, erase and protect mixes
    for (int i = 0; i < 6; i++) begin
      v = {2'h0, i[2:0], 1'b0, i[1:0], 17'h0, i[0], 3'h0, i[2], 2'h0};
      wb(1'b1, 4'h0, v);
      wb(1'b0, 4'h0, 32'h0);
      chk(q, v);
      chk(32'(exp_multiplier_o), 4 * i[2] + 2 * i[0] + i[1:0]);
      chk(32'({protect_set_o, protect_clear_o, erase_select_o}), 32'({i[0] & ~i[2],
        i[0] & i[2], i[2]}));
    end
    // arm, then try to change every field but the armed bit
    wb(1'b1, 4'h0, 32'h0800_8000);
    wb(1'b1, 4'h0, 32'h0800_8002);
    wb(1'b1, 4'h0, 32'hEFFF_FFFE);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0800_8002);
    chk({23'h0, sequence_armed_o, block_select_o}, 32'h0000_0101);
    // pulse with array requests pending; disarm refused meanwhile
    array_req_i <= 1'b1;
    wb(1'b1, 4'h4, 32'h1);
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h8800_8002);
    for (n = 0; n < 600 && high_voltage_active_o !== 1'b0; n++) @(posedge clk_i);
    chk(32'(n > 200 && n < 600), 32'h1);
    for (n = 0; n < 4 && array_ack_o !== 1'b1; n++) @(posedge clk_i);
    chk(32'(n < 4), 32'h1);
    array_req_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0800_8002);
    // unmapped place reads zero
    wb(1'b1, 4'h8, 32'hFFFF_FFFF);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    // protection clear on the small array: blocks 6 and 7 set as well
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b1, 4'h0, 32'h0800_0346);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0800_0346);
    chk({21'h0, protect_set_o, protect_clear_o, erase_select_o, block_select_o},
      32'h0000_03C0);
    // N = 0 + 4 + 2: 64 ticks of two clocks, plus one
    wb(1'b1, 4'h4, 32'h1);
    for (n = 0; n < 600 && high_voltage_active_o !== 1'b0; n++) @(posedge clk_i);
    chk(32'(pulse_len), 32'h81);
    // each valid range code on a one-tick pulse: twice the scaling plus one clock
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, 4'h0, 32'h0);
      wb(1'b1, 4'h0, {2'h0, c[2:0], 27'h000_8002});
      wb(1'b1, 4'h4, 32'h1);
      for (n = 0; n < 600 && high_voltage_active_o !== 1'b0; n++) @(posedge clk_i);
      chk(32'(n > 240 && n < 600), 32'h1);
      chk(32'(pulse_len), twice_scale[c] + 32'h1);
    end
    close_out();
  end
endmodule : tb_top
